// file: verilog/fmcr_pkg.sv
// Functional notes
// - Upper error count holds; refreshes only after lower count register is read.
// - Upper count clears only on clear-counter write of one; not on reads or soft reset.
// - Reading lower count captures matching upper half as one consistent snapshot.
// - Bit 14 enables 1000BASE-X filtering, bit 13 100BASE-FX filtering; both reset 0.
// - Bit 9 enables 100BASE-FX far-end fault report; resets to 0.
// - Bit 6 permits serial auto-negotiation bypass; hardware reset value 1.
// - Bypass enable and sleep policy take effect only at software reset.
// - Bypass status reads 1 when link came up through bypass timer expiry.
// - Bypass status reads 0 after normal negotiation; resets to 0.
// - While bypass status is 1, negotiation-complete status reads 0.
// - Bit 3 set disables the fiber transmitter; resets to 0.
// - Amplitude code 111 largest, each step about 98 mV less; reset 010.
// - Sleep policy bit 1 keeps host side powered; 0 allows power down.
package fmcr_pkg;
    localparam logic [7:0] ADDR_HOST_CTRL = 8'h10;
    localparam logic [7:0] ADDR_ERR_LO = 8'h18;
    localparam logic [7:0] ADDR_ERR_HI = 8'h19;
    localparam logic [7:0] ADDR_FIBER_CTRL = 8'h1A;
    localparam logic [7:0] ADDR_TEST_CTRL = 8'h17;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h21;
    localparam logic [7:0] ADDR_LINK_STAT = 8'h22;
    localparam int BIT_FILT_1000X = 14;
    localparam int BIT_FILT_100FX = 13;
    localparam int BIT_FEFR = 9;
    localparam int BIT_BYP_EN = 6;
    localparam int BIT_BYP_STAT = 5;
    localparam int BIT_TX_DIS = 3;
    localparam int BIT_SLEEP_POL = 3;
    localparam int BIT_CLR_CNT = 4;
    localparam int AMP_MSB = 2;
    localparam logic [15:0] FIBER_CTRL_RST = 16'h0042;
    localparam logic [15:0] FIBER_CTRL_WMASK = 16'hFFDF;
    localparam logic [15:0] FIBER_SOFT_MASK = 16'h1450;
    localparam logic [15:0] HOST_CTRL_RST = 16'hE008;
    localparam logic [15:0] HOST_SOFT_MASK = 16'h0008;
    localparam int IRQ_W = 3;
    localparam int IRQ_SNAP = 0;
    localparam int IRQ_BYPASS_UP = 1;
    localparam int IRQ_NORMAL_UP = 2;
endpackage

// file: verilog/fmcr_regs.sv
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
module fmcr_regs #(
    parameter int CNT_W = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic soft_reset,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [31:0] err_count_live,
    input wire logic link_up_bypass,
    input wire logic link_up_normal,
    input wire logic link_down,
    input wire logic an_complete_raw,
    output logic err_clear,
    output logic [31:0] err_total,
    output logic an_complete,
    output logic filt_1000x_en,
    output logic filt_100fx_en,
    output logic far_end_fault_report_en,
    output logic bypass_allowed,
    output logic tx_disable,
    output logic [2:0] amp_code,
    output logic host_side_sleep_policy,
    output logic host_side_power_down_ok,
    input wire logic pwr_down_cmd,
    input wire logic energy_detect_state,
    output logic irq
);
    logic [CNT_W-1:0] err_lo_r;
    logic [CNT_W-1:0] err_hi_r;
    logic [15:0] fiber_r;
    logic [15:0] host_r;
    logic byp_stat_r;
    logic byp_en_act_r;
    logic sleep_act_r;
    logic [fmcr_pkg::IRQ_W-1:0] irq_stat_r;
    logic [fmcr_pkg::IRQ_W-1:0] irq_mask_r;
    logic [fmcr_pkg::IRQ_W-1:0] irq_ev;
    logic clr_wr;
    logic lo_rd;
    logic [15:0] rdata_nxt;

    assign clr_wr = reg_wr && reg_addr == fmcr_pkg::ADDR_TEST_CTRL
        && reg_wdata[fmcr_pkg::BIT_CLR_CNT];
    assign lo_rd = reg_rd && reg_addr == fmcr_pkg::ADDR_ERR_LO;
    assign err_clear = clr_wr;

    // Snapshot both halves on lower read
    always_ff @(posedge sys_clk) begin
        if (!rst_n || clr_wr) begin
            err_lo_r <= '0;
            err_hi_r <= '0;
        end else if (lo_rd) begin
            err_lo_r <= err_count_live[CNT_W-1:0];
            err_hi_r <= err_count_live[2*CNT_W-1:CNT_W];
        end
    end
    assign err_total = {err_hi_r, err_lo_r};

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fiber_r <= fmcr_pkg::FIBER_CTRL_RST;
        end else if (reg_wr && reg_addr == fmcr_pkg::ADDR_FIBER_CTRL) begin
            fiber_r <= reg_wdata & fmcr_pkg::FIBER_CTRL_WMASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            host_r <= fmcr_pkg::HOST_CTRL_RST;
        end else if (reg_wr && reg_addr == fmcr_pkg::ADDR_HOST_CTRL) begin
            host_r <= reg_wdata;
        end
    end

    // Disruptive bits latch only at soft reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            byp_en_act_r <= fmcr_pkg::FIBER_CTRL_RST[fmcr_pkg::BIT_BYP_EN];
            sleep_act_r <= fmcr_pkg::HOST_CTRL_RST[fmcr_pkg::BIT_SLEEP_POL];
        end else if (soft_reset) begin
            byp_en_act_r <= fiber_r[fmcr_pkg::BIT_BYP_EN];
            sleep_act_r <= host_r[fmcr_pkg::BIT_SLEEP_POL];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n || soft_reset || link_down) begin
            byp_stat_r <= 1'b0;
        end else if (link_up_bypass && byp_en_act_r) begin
            byp_stat_r <= 1'b1;
        end else if (link_up_normal) begin
            byp_stat_r <= 1'b0;
        end
    end
    assign an_complete = an_complete_raw && !byp_stat_r;

    assign filt_1000x_en = fiber_r[fmcr_pkg::BIT_FILT_1000X];
    assign filt_100fx_en = fiber_r[fmcr_pkg::BIT_FILT_100FX];
    assign far_end_fault_report_en = fiber_r[fmcr_pkg::BIT_FEFR];
    assign bypass_allowed = byp_en_act_r;
    assign tx_disable = fiber_r[fmcr_pkg::BIT_TX_DIS];
    assign amp_code = fiber_r[fmcr_pkg::AMP_MSB:0];
    assign host_side_sleep_policy = sleep_act_r;
    assign host_side_power_down_ok = !sleep_act_r
        && (pwr_down_cmd || energy_detect_state);

    assign irq_ev[fmcr_pkg::IRQ_SNAP] = lo_rd;
    assign irq_ev[fmcr_pkg::IRQ_BYPASS_UP] = link_up_bypass && byp_en_act_r;
    assign irq_ev[fmcr_pkg::IRQ_NORMAL_UP] = link_up_normal;

    // Set wins over write-one clear
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_stat_r <= '0;
        end else if (reg_wr && reg_addr == fmcr_pkg::ADDR_IRQ_STAT) begin
            irq_stat_r <= (irq_stat_r & ~reg_wdata[fmcr_pkg::IRQ_W-1:0]) | irq_ev;
        end else begin
            irq_stat_r <= irq_stat_r | irq_ev;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_mask_r <= '0;
        end else if (reg_wr && reg_addr == fmcr_pkg::ADDR_IRQ_MASK) begin
            irq_mask_r <= reg_wdata[fmcr_pkg::IRQ_W-1:0];
        end
    end
    assign irq = |(irq_stat_r & irq_mask_r);

    always_comb begin
        rdata_nxt = '0;
        case (reg_addr)
            fmcr_pkg::ADDR_HOST_CTRL: rdata_nxt = host_r;
            fmcr_pkg::ADDR_ERR_LO: rdata_nxt = err_count_live[CNT_W-1:0];
            fmcr_pkg::ADDR_ERR_HI: rdata_nxt = err_hi_r;
            fmcr_pkg::ADDR_FIBER_CTRL: begin
                rdata_nxt = fiber_r;
                rdata_nxt[fmcr_pkg::BIT_BYP_STAT] = byp_stat_r;
            end
            fmcr_pkg::ADDR_IRQ_STAT: rdata_nxt[fmcr_pkg::IRQ_W-1:0] = irq_stat_r;
            fmcr_pkg::ADDR_IRQ_MASK: rdata_nxt[fmcr_pkg::IRQ_W-1:0] = irq_mask_r;
            fmcr_pkg::ADDR_LINK_STAT: rdata_nxt[0] = an_complete;
            default: rdata_nxt = '0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end else begin
            reg_rdata <= '0;
        end
    end
endmodule // fmcr_regs

// file: tb/fmcr_props.sv
`timescale 1ns/1ns
module fmcr_props (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic soft_reset,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic link_up_bypass,
    input wire logic err_clear,
    input wire logic [31:0] err_total,
    input wire logic an_complete,
    input wire logic bypass_allowed,
    input wire logic tx_disable,
    input wire logic [2:0] amp_code,
    input wire logic host_side_sleep_policy,
    input wire logic host_side_power_down_ok,
    input wire logic pwr_down_cmd,
    input wire logic energy_detect_state
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [15:0] wd_r;
    wire lo_e = reg_rd && reg_addr == fmcr_pkg::ADDR_ERR_LO;
    always_ff @(posedge sys_clk) wd_r <= reg_wdata;
    sequence lo_then_data;
        lo_e ##1 reg_rdata == err_total[15:0];
    endsequence
    AST_RST: assert property ($rose(rst_n) |-> amp_code == 3'h2 && !tx_disable
        && bypass_allowed && host_side_sleep_policy) else $error("bad reset value");
    AST_FIELD: assert property (reg_wr && reg_addr == fmcr_pkg::ADDR_FIBER_CTRL
        |=> {tx_disable, amp_code} == wd_r[3:0]) else $error("field not applied");
    AST_HOLD: assert property (!lo_e && !err_clear |=> $stable(err_total))
        else $error("snapshot moved");
    AST_SNAP: assert property (lo_e |-> lo_then_data) else $error("snapshot mismatch");
    AST_CLR: assert property (err_clear |=> err_total[31:16] == 16'h0000)
        else $error("count not cleared");
    AST_POL: assert property (!soft_reset |=> $stable(bypass_allowed)
        && $stable(host_side_sleep_policy)) else $error("policy changed early");
    AST_AN: assert property (link_up_bypass && bypass_allowed |=> !an_complete)
        else $error("complete during bypass");
    AST_PD: assert property (host_side_power_down_ok == (!host_side_sleep_policy
        && (pwr_down_cmd || energy_detect_state))) else $error("power down permit");
endmodule // fmcr_props

// file: tb/fmcr_host.sv
`timescale 1ns/1ns
module fmcr_host (
    input wire logic sys_clk,
    input wire logic [15:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic soft_reset
);
    initial {reg_addr, reg_wdata, reg_wr, reg_rd, soft_reset} = '0;
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
        @(negedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask
    task automatic commit();
        @(posedge sys_clk);
        soft_reset <= 1'b1;
        @(posedge sys_clk);
        soft_reset <= 1'b0;
        @(negedge sys_clk);
    endtask
endmodule // fmcr_host

// file: tb/fmcr_regs_bench.sv
`timescale 1ns/1ns
module fmcr_regs_bench;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rv;
    logic [31:0] err_count_live = 32'h1234_5678;
    logic [31:0] err_total;
    logic [2:0] amp_code;
    logic [1:0] ev = 2'h0;
    logic reg_wr, reg_rd, soft_reset, err_clear, an_complete, filt_1000x_en, filt_100fx_en;
    logic far_end_fault_report_en, bypass_allowed, tx_disable, host_side_sleep_policy, irq;
    logic host_side_power_down_ok, link_down = 1'b0, an_complete_raw = 1'b1;
    logic pwr_down_cmd = 1'b1, energy_detect_state = 1'b0;
    wire link_up_bypass = ev[0];
    wire link_up_normal = ev[1];
    int fail_count = 0, checks_done = 0, cyc = 0;
    fmcr_regs fmcr_regs_inst (.*);
    fmcr_host fmcr_host_inst (.*);
    initial forever #50 sys_clk = ~sys_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic pulse(input int i);
        @(posedge sys_clk);
        ev[i] <= 1'b1;
        @(posedge sys_clk);
        ev[i] <= 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
        fmcr_host_inst.rd(a, rv);
        chk(rv, exp);
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 1000) begin
            fail_count++;
            summarize();
        end
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdc(fmcr_pkg::ADDR_FIBER_CTRL, 16'h0042);
        rdc(fmcr_pkg::ADDR_HOST_CTRL, 16'hE008);
        pulse(0);
        rdc(fmcr_pkg::ADDR_FIBER_CTRL, 16'h0062);
        chk(an_complete, 32'h0);
        pulse(1);
        rdc(fmcr_pkg::ADDR_FIBER_CTRL, 16'h0042);
        chk(an_complete, 32'h1);
        rdc(fmcr_pkg::ADDR_ERR_HI, 16'h0000);
        rdc(fmcr_pkg::ADDR_ERR_LO, 16'h5678);
        err_count_live <= 32'h9999_AAAA;
        rdc(fmcr_pkg::ADDR_ERR_HI, 16'h1234);
        chk(err_total, 32'h1234_5678);
        fmcr_host_inst.wr(fmcr_pkg::ADDR_FIBER_CTRL, 16'hFFFF);
        rdc(fmcr_pkg::ADDR_FIBER_CTRL, 16'hFFDF);
        chk({tx_disable, amp_code}, 32'hF);
        chk({filt_1000x_en, filt_100fx_en}, 32'h3);
        chk(far_end_fault_report_en, 32'h1);
        chk(bypass_allowed, 32'h1);
        fmcr_host_inst.wr(fmcr_pkg::ADDR_FIBER_CTRL, 16'h0000);
        fmcr_host_inst.wr(fmcr_pkg::ADDR_HOST_CTRL, 16'h0000);
        chk({bypass_allowed, host_side_power_down_ok}, 32'h2);
        fmcr_host_inst.commit();
        chk({bypass_allowed, host_side_power_down_ok}, 32'h1);
        chk(host_side_sleep_policy, 32'h0);
        chk({filt_1000x_en, far_end_fault_report_en, tx_disable}, 32'h0);
        rdc(fmcr_pkg::ADDR_ERR_HI, 16'h1234);
        fmcr_host_inst.wr(fmcr_pkg::ADDR_TEST_CTRL, 16'h0010);
        rdc(fmcr_pkg::ADDR_ERR_HI, 16'h0000);
        rdc(fmcr_pkg::ADDR_IRQ_STAT, 16'h0007);
        fmcr_host_inst.wr(fmcr_pkg::ADDR_IRQ_MASK, 16'h0002);
        chk(irq, 32'h1);
        fmcr_host_inst.wr(fmcr_pkg::ADDR_IRQ_STAT, 16'h0002);
        chk(irq, 32'h0);
        rdc(fmcr_pkg::ADDR_IRQ_STAT, 16'h0005);
        rdc(8'h30, 16'h0000);
        summarize();
    end
endmodule // fmcr_regs_bench
bind fmcr_regs fmcr_props fmcr_props_inst (.*);
